// [verilog/oad_pkg.sv]
// Constants and types for the operand addressing decoder.
// Assumes a single core clock; no registers reachable by software.
package oad_pkg;

    // ************************************************************
    // Field encodings
    // ************************************************************
    localparam logic [1:0] OAD_FORM_NODISP   = 2'h0;
    localparam logic [1:0] OAD_FORM_DISP8    = 2'h1;
    localparam logic [1:0] OAD_FORM_DISP16   = 2'h2;
    localparam logic [1:0] OAD_FORM_REG      = 2'h3;
    localparam logic [2:0] OAD_SEL_DIRECT    = 3'h6;
    localparam logic [2:0] OAD_PFX_HI_PAT    = 3'h1;
    localparam logic [2:0] OAD_PFX_LO_PAT    = 3'h6;

    // Segment selectors, as coded in the prefix
    localparam logic [1:0] OAD_SEG_EXTRA     = 2'h0;
    localparam logic [1:0] OAD_SEG_CODE      = 2'h1;
    localparam logic [1:0] OAD_SEG_STACK     = 2'h2;
    localparam logic [1:0] OAD_SEG_DATA      = 2'h3;

    // Register-file indices for base and index sources
    localparam logic [2:0] OAD_REG_BASE      = 3'h3;
    localparam logic [2:0] OAD_REG_FRAME     = 3'h5;
    localparam logic [2:0] OAD_REG_SRCIDX    = 3'h6;
    localparam logic [2:0] OAD_REG_DSTIDX    = 3'h7;

    // Reset values
    localparam logic [15:0] OAD_RST_WORD     = 16'h0000;
    localparam logic [1:0]  OAD_RST_SEG      = 2'h3;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [1:0] {
        OAD_IDLE  = 2'b00,
        OAD_DLOW  = 2'b01,
        OAD_DHIGH = 2'b11
    } oad_state_t;

    typedef struct packed {
        logic       use_base;
        logic [2:0] base_idx;
        logic       use_index;
        logic [2:0] index_idx;
        logic       frame;
    } oad_ea_t;

endpackage : oad_pkg

// [verilog/oad_ea_map.sv]
// Combinational map of operand-select code to base and index sources.
// Assumes the caller handles the direct-address case itself.
`timescale 1ns/100ps
module oad_ea_map
    import oad_pkg::*;
(
    // Select code
    input  wire logic [2:0] sel_i,
    // Sources
    output oad_ea_t         ea_o
);

    always_comb begin
        ea_o = '0;
        unique case (sel_i)
            3'h0: begin
                ea_o = '{1'b1, OAD_REG_BASE, 1'b1, OAD_REG_SRCIDX, 1'b0};
            end
            3'h1: begin
                ea_o = '{1'b1, OAD_REG_BASE, 1'b1, OAD_REG_DSTIDX, 1'b0};
            end
            3'h2: begin
                ea_o = '{1'b1, OAD_REG_FRAME, 1'b1, OAD_REG_DSTIDX, 1'b1};
            end
            3'h3: begin
                ea_o = '{1'b1, OAD_REG_FRAME, 1'b1, OAD_REG_SRCIDX, 1'b1};
            end
            3'h4: begin
                ea_o = '{1'b0, 3'h0, 1'b1, OAD_REG_SRCIDX, 1'b0};
            end
            3'h5: begin
                ea_o = '{1'b0, 3'h0, 1'b1, OAD_REG_DSTIDX, 1'b0};
            end
            3'h6: begin
                ea_o = '{1'b1, OAD_REG_FRAME, 1'b0, 3'h0, 1'b1};
            end
            3'h7: begin
                ea_o = '{1'b1, OAD_REG_BASE, 1'b0, 3'h0, 1'b0};
            end
        endcase
    end

endmodule : oad_ea_map

// [verilog/oad_decoder.sv]
// Operand addressing decoder: addressing byte, displacement, segment.
// Assumes the fetch queue presents one byte per valid cycle, in order.
// Assumes prefix bytes come at least one cycle before the addressing byte they serve.
`timescale 1ns/100ps
module oad_decoder
    import oad_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk_i,
    input  wire logic        sys_rst_i,
    // Prefix byte from fetch
    input  wire logic        prefix_valid_i,
    input  wire logic [7:0]  prefix_byte_i,
    // Addressing byte from fetch
    input  wire logic        modrm_valid_i,
    input  wire logic [7:0]  modrm_byte_i,
    input  wire logic        width_i,
    // Displacement bytes from fetch
    input  wire logic        disp_valid_i,
    input  wire logic [7:0]  disp_byte_i,
    // Decode status
    output logic             busy_o,
    output logic             disp_req_o,
    output logic             done_o,
    // Register operand
    output logic             is_reg_o,
    output logic [3:0]       reg_sel_o,
    output logic             reg_byte_o,
    output logic             reg_high_o,
    // Memory operand
    output logic             use_base_o,
    output logic [2:0]       base_idx_o,
    output logic             use_index_o,
    output logic [2:0]       index_idx_o,
    output logic [15:0]      disp_o,
    output logic [1:0]       segment_o
);

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        oad_state_t  st;
        logic        ovr_valid;
        logic [1:0]  ovr_seg;
        logic        two_bytes;
        logic        busy;
        logic        disp_req;
        logic        done;
        logic        is_reg;
        logic [3:0]  reg_sel;
        logic        reg_byte;
        logic        reg_high;
        logic        use_base;
        logic [2:0]  base_idx;
        logic        use_index;
        logic [2:0]  index_idx;
        logic [15:0] disp;
        logic [1:0]  segment;
    } oad_regs_t;

    oad_regs_t q, d;
    oad_ea_t   ea_map;

    // ************************************************************
    // Address map
    // ************************************************************
    // Base and index choice per select code, shared by all memory forms but the direct address
    oad_ea_map u_ea_map (
        .sel_i (modrm_byte_i[2:0]),
        .ea_o  (ea_map)
    );

    // ************************************************************
    // Decode helpers
    // ************************************************************
    // Prefix pattern test, used by the decode below
    function automatic logic is_seg_prefix(input logic [7:0] b);
        return (b[7:5] == OAD_PFX_HI_PAT) && (b[2:0] == OAD_PFX_LO_PAT);
    endfunction : is_seg_prefix

    // Direct address: no base, two displacement bytes
    function automatic logic is_direct(input logic [1:0] f, input logic [2:0] s);
        return (f == OAD_FORM_NODISP) && (s == OAD_SEL_DIRECT);
    endfunction : is_direct

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        logic [1:0] form;
        logic [2:0] sel;
        form = modrm_byte_i[7:6];
        sel  = modrm_byte_i[2:0];
        // Hold everything but done unless a byte is taken
        d      = q;
        d.done = 1'b0;
        unique case (q.st)
            OAD_IDLE: begin
                if (modrm_valid_i) begin
                    d.is_reg    = (form == OAD_FORM_REG);
                    d.reg_sel   = {width_i, sel};
                    d.reg_byte  = ~width_i;
                    d.reg_high  = ~width_i & sel[2];
                    // Clear memory fields so a register operand shows none
                    d.use_base  = 1'b0;
                    d.base_idx  = 3'h0;
                    d.use_index = 1'b0;
                    d.index_idx = 3'h0;
                    d.disp      = OAD_RST_WORD;
                    d.segment   = OAD_SEG_DATA;
                    if (form != OAD_FORM_REG) begin
                        d.use_base  = ea_map.use_base;
                        d.base_idx  = ea_map.base_idx;
                        d.use_index = ea_map.use_index;
                        d.index_idx = ea_map.index_idx;
                        d.segment   = ea_map.frame ? OAD_SEG_STACK : OAD_SEG_DATA;
                        if (q.ovr_valid) begin
                            d.segment = q.ovr_seg;
                        end
                        if (is_direct(form, sel)) begin
                            d.use_base  = 1'b0;
                            d.use_index = 1'b0;
                            d.segment   = q.ovr_valid ? q.ovr_seg : OAD_SEG_DATA;
                        end
                    end
                    // Override is spent on this operand
                    d.ovr_valid = 1'b0;
                    if (form == OAD_FORM_DISP8) begin
                        d.two_bytes = 1'b0;
                        d.st        = OAD_DLOW;
                        d.disp_req  = 1'b1;
                        d.busy      = 1'b1;
                    end else if (form == OAD_FORM_DISP16 || is_direct(form, sel)) begin
                        d.two_bytes = 1'b1;
                        d.st        = OAD_DLOW;
                        d.disp_req  = 1'b1;
                        d.busy      = 1'b1;
                    end else begin
                        d.done = 1'b1;
                    end
                end
            end
            OAD_DLOW: begin
                // Fetch may stall here without limit; no timeout is kept
                if (disp_valid_i) begin
                    if (q.two_bytes) begin
                        d.disp[7:0] = disp_byte_i;
                        d.st        = OAD_DHIGH;
                    end else begin
                        d.disp     = {{8{disp_byte_i[7]}}, disp_byte_i};
                        d.st       = OAD_IDLE;
                        d.disp_req = 1'b0;
                        d.busy     = 1'b0;
                        d.done     = 1'b1;
                    end
                end
            end
            OAD_DHIGH: begin
                if (disp_valid_i) begin
                    d.disp[15:8] = disp_byte_i;
                    d.st         = OAD_IDLE;
                    d.disp_req   = 1'b0;
                    d.busy       = 1'b0;
                    d.done       = 1'b1;
                end
            end
            default: begin
                d.st = OAD_IDLE;
            end
        endcase
        // Last, so a prefix beside an addressing byte is kept, not spent
        if (prefix_valid_i && is_seg_prefix(prefix_byte_i)) begin
            d.ovr_valid = 1'b1;
            d.ovr_seg   = prefix_byte_i[4:3];
        end
    end

    // ************************************************************
    // Registers
    // ************************************************************
    // Segment resets to data, as for a register operand
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            q         <= '0;
            q.st      <= OAD_IDLE;
            q.disp    <= OAD_RST_WORD;
            q.segment <= OAD_RST_SEG;
            q.ovr_seg <= OAD_RST_SEG;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    // Plain register taps; nothing combinational reaches a pin
    assign busy_o      = q.busy;
    assign disp_req_o  = q.disp_req;
    assign done_o      = q.done;
    assign is_reg_o    = q.is_reg;
    assign reg_sel_o   = q.reg_sel;
    assign reg_byte_o  = q.reg_byte;
    assign reg_high_o  = q.reg_high;
    assign use_base_o  = q.use_base;
    assign base_idx_o  = q.base_idx;
    assign use_index_o = q.use_index;
    assign index_idx_o = q.index_idx;
    assign disp_o      = q.disp;
    assign segment_o   = q.segment;

endmodule : oad_decoder

// [verif/oad_decoder_checker.sv]
// Port checks for the operand addressing decoder.
// Assumes binding to oad_decoder; one clock, async reset.
`timescale 1ns/100ps
module oad_decoder_checker
    import oad_pkg::*;
(
    input wire logic ref_clk_i, sys_rst_i, modrm_valid_i, width_i, disp_valid_i, busy_o,
    input wire logic disp_req_o, done_o, is_reg_o, reg_byte_o, reg_high_o, use_base_o,
    input wire logic use_index_o,
    input wire logic [7:0] modrm_byte_i, disp_byte_i,
    input wire logic [3:0] reg_sel_o,
    input wire logic [2:0] base_idx_o, index_idx_o,
    input wire logic [15:0] disp_o
);
    // Per select: use_base, base, use_index, index
    localparam logic [63:0] EA_TAB = 64'hB0D0_0F0E_DEDF_BFBE;
    logic [1:0] form_q;
    logic [2:0] sel_q;
    logic [7:0] lo_q, e;
    logic w_q, nb_q, take, dtake, drct;
    assign take = modrm_valid_i && !busy_o;
    assign dtake = disp_valid_i && disp_req_o;
    assign drct = form_q == 2'h0 && sel_q == OAD_SEL_DIRECT;
    assign e = EA_TAB[{sel_q, 3'h0} +: 8];
    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) {form_q, sel_q, lo_q, w_q, nb_q} <= '0;
        else if (take) {form_q, sel_q, w_q, nb_q} <= {modrm_byte_i[7:6], modrm_byte_i[2:0],
            width_i, 1'h0};
        else if (dtake) {nb_q, lo_q} <= {1'h1, disp_byte_i};
    end
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);
    reg_form_a: assert property (take && modrm_byte_i[7:6] == 2'h3 |=>
        done_o && is_reg_o && disp_o == 16'h0000) else $error("register form");
    no_disp_a: assert property (take && modrm_byte_i[7:6] == 2'h0 &&
        modrm_byte_i[2:0] != 3'h6 |=> done_o && disp_o == 16'h0000) else $error("no disp");
    disp_wait_a: assert property (take && modrm_byte_i[7:6] inside {2'h1, 2'h2} |=>
        busy_o && disp_req_o && !done_o) else $error("disp wait");
    disp8_a: assert property (dtake && form_q == 2'h1 |=> done_o &&
        disp_o == {{8{$past(disp_byte_i[7])}}, $past(disp_byte_i)}) else $error("disp8");
    disp16_a: assert property (dtake && nb_q && (form_q == 2'h2 || drct) |=>
        done_o && disp_o == {$past(disp_byte_i), $past(lo_q)}) else $error("disp16");
    ea_map_a: assert property (done_o && !is_reg_o && !drct |->
        use_base_o == e[7] && use_index_o == e[3] && (!e[7] || base_idx_o == e[6:4])
        && (!e[3] || index_idx_o == e[2:0])) else $error("base or index");
    direct_a: assert property (done_o && drct |->
        !is_reg_o && !use_base_o && !use_index_o) else $error("direct");
    reg_sel_a: assert property (done_o && is_reg_o |-> reg_sel_o == {w_q, sel_q} &&
        reg_byte_o == !w_q && reg_high_o == (!w_q && sel_q[2])) else $error("reg select");
    cover property (dtake && nb_q);
    cover property (done_o && is_reg_o && !w_q);
    cover property (done_o && drct);
endmodule : oad_decoder_checker

bind oad_decoder oad_decoder_checker u_oad_decoder_checker (.*);

// [verif/oad_fetch_model.sv]
// Fetch queue model: gives displacement bytes at falling edges.
// Assumes the decoder holds disp_req_i while it wants bytes.
`timescale 1ns/100ps
module oad_fetch_model (
    input  wire logic        ref_clk_i,
    input  wire logic        disp_req_i,
    input  wire logic        slow_i,
    input  wire logic [15:0] word_i,
    output logic             disp_valid_o = 1'h0,
    output logic [7:0]       disp_byte_o = 8'h00
);
    logic hi_q = 1'h0;
    always @(posedge ref_clk_i) hi_q <= disp_req_i && (hi_q || disp_valid_o);
    // Idle byte toggles so a stale byte cannot pass as fresh
    always @(negedge ref_clk_i) begin
        disp_valid_o <= disp_req_i && !slow_i;
        disp_byte_o <= disp_req_i && !slow_i ? word_i[{hi_q, 3'h0} +: 8] : ~disp_byte_o;
    end
endmodule : oad_fetch_model

// [verif/oad_decoder_tb.sv]
// Self-checking bench for the operand addressing decoder.
// Assumes the fetch model answers every displacement request.
`timescale 1ns/100ps
module oad_decoder_tb
    import oad_pkg::*;
();
    typedef struct packed {
        logic [7:0] m; logic [15:0] d, ed; logic [1:0] es; logic [7:0] ea;
    } oad_row_t;
    localparam oad_row_t ROWS [10] = '{'{8'h00, 16'h0000, 16'h0000, 2'h3, 8'hBE},
        '{8'h42, 16'h0080, 16'hFF80, 2'h2, 8'hDF}, '{8'h83, 16'h1234, 16'h1234, 2'h2, 8'hDE},
        '{8'h06, 16'hBEEF, 16'hBEEF, 2'h3, 8'h00}, '{8'h85, 16'h8001, 16'h8001, 2'h3, 8'h0F},
        '{8'h46, 16'h0001, 16'h0001, 2'h2, 8'hD0}, '{8'hC5, 16'h0000, 16'h0000, 2'h3, 8'h00},
        '{8'h01, 16'h0000, 16'h0000, 2'h3, 8'hBF}, '{8'h44, 16'h007F, 16'h007F, 2'h3, 8'h0E},
        '{8'hBF, 16'hC3A5, 16'hC3A5, 2'h3, 8'hB0}};
    logic ref_clk_i = 1'h0, sys_rst_i = 1'h1, prefix_valid_i = 1'h0, modrm_valid_i = 1'h0;
    logic width_i = 1'h0, fm_slow = 1'h0, disp_valid_i, busy_o, disp_req_o, done_o;
    logic is_reg_o, reg_byte_o, reg_high_o, use_base_o, use_index_o;
    logic [7:0] prefix_byte_i = 8'h00, modrm_byte_i = 8'h00, disp_byte_i;
    logic [15:0] disp_o, fm_word = 16'h0000;
    logic [3:0] reg_sel_o;
    logic [2:0] base_idx_o, index_idx_o;
    logic [1:0] segment_o;
    logic [7:0] ea_seen;
    // Unused base or index fields read as zero, whatever they hold
    assign ea_seen = {use_base_o, use_base_o ? base_idx_o : 3'h0, use_index_o,
        use_index_o ? index_idx_o : 3'h0};
    int err_total = 0, n_tests = 0;
    oad_decoder u_oad_decoder (.*);
    oad_fetch_model u_oad_fetch_model (.ref_clk_i, .disp_req_i(disp_req_o), .slow_i(fm_slow),
        .word_i(fm_word), .disp_valid_o(disp_valid_i), .disp_byte_o(disp_byte_i));
    initial forever #2.5 ref_clk_i = ~ref_clk_i;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : finish_test
    // Prefix goes one cycle ahead, else it waits for the next operand
    task automatic issue(input logic [7:0] p, input logic [7:0] m, input logic w);
        @(negedge ref_clk_i);
        {prefix_valid_i, prefix_byte_i} = {p != 8'h00, p};
        @(negedge ref_clk_i);
        {prefix_valid_i, modrm_valid_i, modrm_byte_i, width_i} = {2'h1, m, w};
        @(negedge ref_clk_i);
        modrm_valid_i = 1'h0;
        for (int k = 0; k < 40 && done_o !== 1'h1; k++) @(negedge ref_clk_i);
        chk(16'(done_o), 16'h0001);
    endtask : issue
    initial begin
        #(5 * 4000);
        err_total++;
        finish_test();
    end
    initial begin
        repeat (20) @(posedge ref_clk_i);
        @(negedge ref_clk_i);
        sys_rst_i = 1'h0;
        foreach (ROWS[i]) begin
            fm_word = ROWS[i].d;
            issue(8'h00, ROWS[i].m, i[0]);
            chk(disp_o, ROWS[i].ed);
            chk(16'(segment_o), 16'(ROWS[i].es));
            chk(16'(is_reg_o), 16'(ROWS[i].m[7:6] == 2'h3));
            chk(16'(ea_seen), 16'(ROWS[i].ea));
            $display("row %0d done", i);
        end
        for (int s = 0; s < 4; s++) begin
            issue({3'h1, 2'(s), 3'h6}, 8'h46, 1'h1);
            chk(16'(segment_o), 16'(s));
        end
        issue(8'h27, 8'h46, 1'h1);
        chk(16'(segment_o), 16'h0002);
        // Prefix beside an addressing byte serves the operand after it
        @(negedge ref_clk_i);
        {prefix_valid_i, prefix_byte_i, modrm_valid_i, modrm_byte_i} = {1'h1, 8'h26, 1'h1, 8'h00};
        @(negedge ref_clk_i);
        {prefix_valid_i, modrm_valid_i} = 2'h0;
        chk(16'(segment_o), 16'h0003);
        issue(8'h00, 8'h00, 1'h1);
        chk(16'(segment_o), 16'h0000);
        $display("prefix test done");
        fm_slow <= 1'h1;
        fm_word = 16'hA55A;
        {modrm_valid_i, modrm_byte_i} = {1'h1, 8'h80};
        @(negedge ref_clk_i);
        modrm_byte_i = 8'hC0;
        repeat (6) @(negedge ref_clk_i);
        chk(16'(busy_o), 16'h0001);
        {fm_slow, modrm_valid_i} <= 2'h0;
        repeat (4) @(negedge ref_clk_i);
        chk(disp_o, 16'hA55A);
        $display("stall test done");
        sys_rst_i = 1'h1;
        @(negedge ref_clk_i);
        chk(16'({done_o, busy_o, is_reg_o, segment_o}), 16'h0003); // RESET
        sys_rst_i = 1'h0;
        issue(8'h00, 8'hC6, 1'h0);
        chk(16'({reg_sel_o, reg_byte_o, reg_high_o}), 16'h001B);
        $display("reset test done");
        finish_test();
    end
endmodule : oad_decoder_tb
